/* src/tpp_config_regs.sv */
// APB register bank for PA and PLL configuration with registered decoded outputs
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Boost bit set puts the amplifier into boost output power mode.
// - Enabled parallel drivers equal driver-count code plus one.
// - Shunt capacitance is 175 fF per code step, zero at code 0.
// - Pump offset code gives none, 5, 10 or 15 percent.
// - Fractional bit 0 selects integer-N, 1 fractional-N.
// - LO divider code: off, divide by 4, 8, 12.
// - LO generator bit 0 ring oscillator, 1 LC VCO.
// - Pump current code gives 5, 10, 15 or 20 microamps.
module tpp_config_regs (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tpp_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Power amplifier controls
  output logic amp_power_boost,
  output logic [7:0] amp_driver_enables,
  output logic [12:0] amp_shunt_cap_ff,
  // PLL controls
  output logic [4:0] pump_offset_pct,
  output logic pll_fractional_select,
  output logic [3:0] lo_divide_ratio,
  output logic lo_generator_select,
  output logic [4:0] pump_current_ua
);
  tpp_reg_if regs ();

  logic [7:0] boost_reg, driver_reg, cap_reg, mode_reg, pump_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  // Address decode of word index
  function automatic logic hit(input logic [tpp_pkg::ADDR_W-1:0] a, input logic [7:0] idx);
    return a == (tpp_pkg::ADDR_W'(idx) << tpp_pkg::BYTE_SHIFT);
  endfunction : hit

  wire setup = psel && !penable;
  wire sel_boost = hit(paddr, tpp_pkg::IDX_AMP_POWER_BOOST_CONTROL);
  wire sel_driver = hit(paddr, tpp_pkg::IDX_PA_DRIVER_CONTROL);
  wire sel_cap = hit(paddr, tpp_pkg::IDX_PA_CAPACITANCE_CONTROL);
  wire sel_mode = hit(paddr, tpp_pkg::IDX_PLL_MODE_CONTROL);
  wire sel_pump = hit(paddr, tpp_pkg::IDX_PLL_PUMP_CONTROL);
  wire mapped = sel_boost | sel_driver | sel_cap | sel_mode | sel_pump;
  // Commit at the access edge that completes the transfer
  wire wr_go = psel && penable && pready_reg && pwrite && mapped && pstrb[0];
  wire [7:0] wbyte = pwdata[7:0];

  wire [7:0] rd_byte =
      ({8{sel_boost}} & boost_reg) |
      ({8{sel_driver}} & driver_reg) |
      ({8{sel_cap}} & cap_reg) |
      ({8{sel_mode}} & mode_reg) |
      ({8{sel_pump}} & pump_reg);
  wire [31:0] rd_next = {24'h00_0000, rd_byte};

  // No wait state: data staged in setup, answer in first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= tpp_pkg::SLVERR_NONE;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup && !mapped;
      if (setup && !pwrite) begin
        prdata_reg <= rd_next;
      end
    end
  end

  // Stored bits only at implemented positions; unimplemented bits do not rely on host value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boost_reg <= tpp_pkg::RST_AMP_POWER_BOOST;
      driver_reg <= tpp_pkg::RST_PA_DRIVER;
      cap_reg <= tpp_pkg::RST_PA_CAP;
      mode_reg <= tpp_pkg::RST_PLL_MODE;
      pump_reg <= tpp_pkg::RST_PLL_PUMP;
    end else if (wr_go) begin
      if (sel_boost) boost_reg <= wbyte & tpp_pkg::MASK_AMP_POWER_BOOST;
      if (sel_driver) driver_reg <= wbyte & tpp_pkg::MASK_PA_DRIVER;
      if (sel_cap) cap_reg <= wbyte & tpp_pkg::MASK_PA_CAP;
      // No interlock on the host keeps offset at zero in integer-N
      if (sel_mode) mode_reg <= wbyte & tpp_pkg::MASK_PLL_MODE;
      if (sel_pump) pump_reg <= wbyte & tpp_pkg::MASK_PLL_PUMP;
    end
  end

  assign regs.boost_reg = boost_reg;
  assign regs.driver_reg = driver_reg;
  assign regs.cap_reg = cap_reg;
  assign regs.mode_reg = mode_reg;
  assign regs.pump_reg = pump_reg;

  logic d_boost, d_frac, d_logen;
  logic [7:0] d_drv;
  logic [12:0] d_cap;
  logic [4:0] d_offs, d_pump;
  logic [3:0] d_div;

  tpp_field_decode u_dec (
    .regs(regs.dec),
    .amp_power_boost(d_boost),
    .amp_driver_enables(d_drv),
    .amp_shunt_cap_ff(d_cap),
    .pump_offset_pct(d_offs),
    .pll_fractional_select(d_frac),
    .lo_divide_ratio(d_div),
    .lo_generator_select(d_logen),
    .pump_current_ua(d_pump)
  );

  // Registered so analog controls never see decode glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp_power_boost <= tpp_pkg::RST_OUT_BOOST;
      amp_driver_enables <= tpp_pkg::RST_OUT_DRIVERS;
      amp_shunt_cap_ff <= tpp_pkg::RST_OUT_CAP;
      pump_offset_pct <= tpp_pkg::RST_OUT_OFFSET;
      pll_fractional_select <= tpp_pkg::RST_OUT_FRAC;
      lo_divide_ratio <= tpp_pkg::RST_OUT_DIVIDE;
      lo_generator_select <= tpp_pkg::RST_OUT_LOGEN;
      pump_current_ua <= tpp_pkg::RST_OUT_PUMP;
    end else begin
      amp_power_boost <= d_boost;
      amp_driver_enables <= d_drv;
      amp_shunt_cap_ff <= d_cap;
      pump_offset_pct <= d_offs;
      pll_fractional_select <= d_frac;
      lo_divide_ratio <= d_div;
      lo_generator_select <= d_logen;
      pump_current_ua <= d_pump;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
endmodule : tpp_config_regs
`default_nettype wire

/* src/tpp_field_decode.sv */
// Decoder from stored register fields to analog control codes
`timescale 1ns/1ps
`default_nettype none
module tpp_field_decode (
  // Stored registers
  tpp_reg_if.dec regs,
  // Decoded controls
  output logic amp_power_boost,
  output logic [7:0] amp_driver_enables,
  output logic [12:0] amp_shunt_cap_ff,
  output logic [4:0] pump_offset_pct,
  output logic pll_fractional_select,
  output logic [3:0] lo_divide_ratio,
  output logic lo_generator_select,
  output logic [4:0] pump_current_ua
);
  wire [2:0] drv_code = regs.driver_reg[tpp_pkg::POS_DRV_LSB +: 3];
  wire [4:0] cap_code = regs.cap_reg[tpp_pkg::POS_CAP_LSB +: 5];
  wire [1:0] offs_code = regs.mode_reg[tpp_pkg::POS_OFFS_LSB +: 2];
  wire [1:0] div_code = regs.mode_reg[tpp_pkg::POS_LO_DIVIDER_SELECT_LSB +: 2];
  wire [1:0] pump_code = regs.pump_reg[tpp_pkg::POS_PUMP_LSB +: 2];

  // Thermometer: code plus one drivers on
  function automatic logic [7:0] therm(input logic [2:0] c);
    logic [8:0] t;
    t = 9'h002 << c;
    return 8'(t - 9'h001);
  endfunction : therm

  assign amp_power_boost = regs.boost_reg[tpp_pkg::POS_BOOST];
  assign amp_driver_enables = therm(drv_code);
  assign amp_shunt_cap_ff = 13'(cap_code) * tpp_pkg::CAP_STEP_FF;
  assign pump_offset_pct = 5'(offs_code) * tpp_pkg::OFFSET_STEP_PCT;
  assign pll_fractional_select = regs.mode_reg[tpp_pkg::POS_FRAC];
  // Zero ratio means divider off
  assign lo_divide_ratio = 4'(div_code) * tpp_pkg::LO_DIVIDER_SELECT_STEP;
  assign lo_generator_select = regs.mode_reg[tpp_pkg::POS_LOGEN];
  assign pump_current_ua = 5'(5'(pump_code) + 5'h01) * tpp_pkg::PUMP_STEP_UA;
endmodule : tpp_field_decode
`default_nettype wire

/* src/tpp_pkg.sv */
// Register map, field layout and decode constants for the PA and PLL configuration bank
package tpp_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_AMP_POWER_BOOST_CONTROL = 8'h05;
  localparam logic [7:0] IDX_PA_DRIVER_CONTROL = 8'h06;
  localparam logic [7:0] IDX_PA_CAPACITANCE_CONTROL = 8'h07;
  localparam logic [7:0] IDX_PLL_MODE_CONTROL = 8'h08;
  localparam logic [7:0] IDX_PLL_PUMP_CONTROL = 8'h09;
  localparam int BYTE_SHIFT = 2;
  localparam int ADDR_W = 12;

  // Implemented-bit masks; other positions read as zero
  localparam logic [7:0] MASK_AMP_POWER_BOOST = 8'h07;
  localparam logic [7:0] MASK_PA_DRIVER = 8'hE7;
  localparam logic [7:0] MASK_PA_CAP = 8'h1F;
  localparam logic [7:0] MASK_PLL_MODE = 8'hFF;
  localparam logic [7:0] MASK_PLL_PUMP = 8'hC3;

  // Reset values
  localparam logic [7:0] RST_AMP_POWER_BOOST = 8'h04;
  localparam logic [7:0] RST_PA_DRIVER = 8'h80;
  localparam logic [7:0] RST_PA_CAP = 8'h00;
  localparam logic [7:0] RST_PLL_MODE = 8'h60;
  localparam logic [7:0] RST_PLL_PUMP = 8'h00;

  // Decoded control values that match the register reset values
  localparam logic RST_OUT_BOOST = 1'h0;
  localparam logic [7:0] RST_OUT_DRIVERS = 8'h01;
  localparam logic [12:0] RST_OUT_CAP = 13'h0000;
  localparam logic [4:0] RST_OUT_OFFSET = 5'h05;
  localparam logic RST_OUT_FRAC = 1'h1;
  localparam logic [3:0] RST_OUT_DIVIDE = 4'h0;
  localparam logic RST_OUT_LOGEN = 1'h0;
  localparam logic [4:0] RST_OUT_PUMP = 5'h05;

  // Field positions
  localparam int POS_BOOST = 0;
  localparam int POS_DRV_LSB = 0;
  localparam int POS_CAP_LSB = 0;
  localparam int POS_OFFS_LSB = 6;
  localparam int POS_FRAC = 5;
  localparam int POS_LO_DIVIDER_SELECT_LSB = 1;
  localparam int POS_LOGEN = 0;
  localparam int POS_PUMP_LSB = 0;

  // Decode scales
  localparam logic [12:0] CAP_STEP_FF = 13'h00AF;
  localparam logic [4:0] OFFSET_STEP_PCT = 5'h05;
  localparam logic [4:0] PUMP_STEP_UA = 5'h05;
  localparam logic [3:0] LO_DIVIDER_SELECT_STEP = 4'h4;

  localparam logic [31:0] SLVERR_NONE = 32'h0000_0000;

endpackage : tpp_pkg

/* src/tpp_reg_if.sv */
// Stored register bundle between the register bank and its decoder
`timescale 1ns/1ps
`default_nettype none
interface tpp_reg_if;
  logic [7:0] boost_reg;
  logic [7:0] driver_reg;
  logic [7:0] cap_reg;
  logic [7:0] mode_reg;
  logic [7:0] pump_reg;
  modport bank (output boost_reg, driver_reg, cap_reg, mode_reg, pump_reg);
  modport dec (input boost_reg, driver_reg, cap_reg, mode_reg, pump_reg);
endinterface : tpp_reg_if
`default_nettype wire

/* verif/tpp_config_regs_assertions.sv */
// Port-level checks for the PA and PLL configuration bank
`timescale 1ns/1ps
`default_nettype none
module tpp_config_regs_assertions (
  // Clock, reset and APB
  input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [tpp_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [3:0] pstrb,
  // Decoded controls
  input wire logic amp_power_boost, pll_fractional_select,
  input wire logic [7:0] amp_driver_enables,
  input wire logic [12:0] amp_shunt_cap_ff,
  input wire logic [4:0] pump_current_ua
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completing write on lane 0, mapped or unmapped address
  wire acc = psel && penable && pready && pwrite && pstrb[0];
  wire mapped = paddr inside {12'h014, 12'h018, 12'h01C, 12'h020, 12'h024};
  chk_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready");
  chk_ready_one_cycle: assert property (pready |=> !pready) else $error("ready too long");
  chk_unmapped_err: assert property (psel && !penable && !mapped |=> pslverr) else $error("no err");
  chk_read_upper_zero: assert property (pready |-> prdata[31:8] == 24'h00_0000) else $error("upper");
  chk_boost_follows: assert property (acc && paddr == 12'h014 |=> ##1
    amp_power_boost == $past(pwdata[0], 2)) else $error("boost");
  chk_frac_follows: assert property (acc && paddr == 12'h020 |=> ##1
    pll_fractional_select == $past(pwdata[5], 2)) else $error("frac");
  chk_driver_thermo: assert property (amp_driver_enables[0] &&
    (amp_driver_enables & (amp_driver_enables + 8'h01)) == 8'h00) else $error("drivers");
  chk_cap_step: assert property (amp_shunt_cap_ff % 175 == 0) else $error("cap step");
  chk_pump_set: assert property (pump_current_ua inside {5, 10, 15, 20}) else $error("pump");
  cov_write: cover property (acc);
  cov_read: cover property (pready && !pwrite && !pslverr);
  cov_err: cover property (pslverr);
endmodule : tpp_config_regs_assertions
bind tpp_config_regs tpp_config_regs_assertions tpp_config_regs_assertions_inst (.pclk, .presetn,
  .psel, .penable, .pwrite, .pready, .pslverr, .paddr, .pwdata, .prdata, .pstrb, .amp_power_boost,
  .pll_fractional_select, .amp_driver_enables, .amp_shunt_cap_ff, .pump_current_ua);
`default_nettype wire

/* verif/tpp_config_regs_bench.sv */
// Self-checking bench for the PA and PLL configuration bank
`timescale 1ns/1ps
`default_nettype none
module tpp_config_regs_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0] pstrb = 0, div;
  logic pready, pslverr, boost, frac, logen, err;
  logic [7:0] drv;
  logic [12:0] cap;
  logic [4:0] offs, pump;
  int fails = 0, tests_run = 0;
  tpp_config_regs tpp_config_regs_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .amp_power_boost(boost),
    .amp_driver_enables(drv), .amp_shunt_cap_ff(cap), .pump_offset_pct(offs),
    .pll_fractional_select(frac), .lo_divide_ratio(div), .lo_generator_select(logen),
    .pump_current_ua(pump));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; idle cycle first so no signal is assigned twice at one edge
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
      input logic [3:0] s);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : xfer
  // Write, then wait for the decoded outputs one edge later
  task automatic wrs(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1, d, 4'h1);
    @(posedge pclk);
    #1;
  endtask : wrs
  task automatic rb(input logic [11:0] a, input logic [31:0] exp);
    xfer(a, 0, 0, 4'h0);
    chk(rd, exp);
    chk(err, 1'b0);
  endtask : rb
  task automatic t_reset;
    rb(12'h014, 8'h04); rb(12'h018, 8'h80); rb(12'h01C, 0); rb(12'h020, 8'h60);
    rb(12'h024, 0);
    chk({boost, drv, cap}, {1'b0, 8'h01, 13'h0000});
    chk({offs, frac, div, logen, pump}, {5'h05, 1'b1, 4'h0, 1'b0, 5'h05});
    $display("reset values done");
  endtask : t_reset
  task automatic t_pa;
    for (int i = 0; i < 8; i++) begin
      wrs(12'h018, 8'h80 | i);
      chk(drv, (9'h001 << (i + 1)) - 1);
      rb(12'h018, 8'h80 | i);
    end
    for (int i = 0; i < 32; i++) begin
      wrs(12'h01C, i);
      chk(cap, 175 * i);
    end
    wrs(12'h014, 5);
    chk(boost, 1);
    wrs(12'h014, 4);
    chk(boost, 0);
    $display("amplifier fields done");
  endtask : t_pa
  task automatic t_pll;
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      // Integer-N only with offset code 0
      v = {i[1:0], i != 0, 2'b00, i[1:0], i[0]};
      wrs(12'h020, v);
      chk(offs, 5 * i);
      chk(frac, i != 0);
      chk(div, 4 * i);
      chk(logen, i % 2);
      rb(12'h020, v);
      wrs(12'h024, i);
      chk(pump, 5 * i + 5);
    end
    $display("pll fields done");
  endtask : t_pll
  task automatic t_refuse;
    xfer(12'h028, 1, 32'h0000_00FF, 4'h1);
    chk(err, 1);
    xfer(12'h028, 0, 0, 4'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0000_0000);
    xfer(12'h014, 1, 32'h0000_0001, 4'h0);
    chk(err, 1'b0);
    rb(12'h014, 8'h04);
    wrs(12'h014, 8'hFF);
    rb(12'h014, 8'h07);
    wrs(12'h01C, 8'hFF);
    rb(12'h01C, 8'h1F);
    wrs(12'h024, 8'hFF);
    rb(12'h024, 8'hC3);
    $display("refusals done");
  endtask : t_refuse
  // Reset in mid-run must restore every register and control
  task automatic t_midreset;
    @(posedge pclk);
    presetn <= 0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    t_reset();
    $display("mid-run reset done");
  endtask : t_midreset
  task automatic conclude;
    $display("tests_run %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  initial begin
    forever #5 pclk = ~pclk;
  end
  // Far above the 82 transfers of the run
  initial begin
    #200000;
    fails++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    t_reset();
    t_pa();
    t_pll();
    t_refuse();
    t_midreset();
    conclude();
  end
endmodule : tpp_config_regs_bench
`default_nettype wire
